// ==== inc/rsi_pkg.sv ====
// Package of types and constants for the reset initial state logic.
package rsi_pkg;

    // Operating state of the core when a reset event arrives.
    typedef enum logic [1:0] {
        RSI_MODE_FAST,
        RSI_MODE_SLOW,
        RSI_MODE_IDLE,
        RSI_MODE_SLEEP
    } rsi_mode_e;

    // Kind of reset decided in the cycle it arrives.
    typedef enum logic [2:0] {
        RSI_KIND_NONE,
        RSI_KIND_POR,
        RSI_KIND_LVR,
        RSI_KIND_WDT_RUN,
        RSI_KIND_WDT_IDLE
    } rsi_kind_e;

    // Target of a software write to one of the reset-defaulted registers.
    typedef enum logic [1:0] {
        RSI_SEL_INT_EN,
        RSI_SEL_TMR_EN,
        RSI_SEL_DIR_A,
        RSI_SEL_DIR_B
    } rsi_sel_e;

    // Reset events other than power-on, each a one-cycle pulse.
    typedef struct packed {
        logic low_voltage_reset;
        logic watchdog_timer;
    } rsi_event_s;

    // Software write strobe with its target and data.
    typedef struct packed {
        logic       we;
        rsi_sel_e   sel;
        logic [7:0] data;
    } rsi_sw_wr_s;

    // Timeout and power-down flags of the status register.
    typedef struct packed {
        logic timeout_flag;
        logic powerdown_flag;
    } rsi_flags_s;

    localparam int         RSI_DATA_W       = 8;
    localparam logic [7:0] RSI_INT_EN_RST   = 8'h00;
    localparam logic [7:0] RSI_TMR_EN_RST   = 8'h00;
    localparam logic [7:0] RSI_DIR_RST      = 8'hff;
    localparam logic       RSI_FLAG_POR     = 1'b0;
    localparam logic       RSI_FLAG_SET     = 1'b1;
    localparam int         RSI_HOLD_CYCLES  = 1;

endpackage

// ==== design/rsi_def_reg.sv ====
// One register that loads a reset default or keeps its contents.
`timescale 1ns/1ps

module rsi_def_reg #(
    parameter int               WIDTH   = 8,
    parameter logic [WIDTH-1:0] DEFAULT = '0
) (
    input  wire logic             sys_clk_in,
    input  wire logic             load_default_in,
    input  wire logic             we_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    output logic      [WIDTH-1:0] q_out
);

    // A default load outranks a write so a reset always lands cleanly.
    always_ff @(posedge sys_clk_in) begin
        if (load_default_in) begin
            q_out <= DEFAULT;
        end else if (we_in) begin
            q_out <= wdata_in;
        end
    end

endmodule

// ==== design/rsi_reset_state.sv ====
// Reset initial state logic: status flags, core reset values and peripheral defaults.
//
// Notes on behaviour
// - Power-on reset clears timeout and power-down flags to zero.
// - Low-voltage reset in fast or slow state leaves both flags unchanged.
// - Running watchdog reset sets timeout flag, keeps power-down flag.
// - Watchdog reset in idle or sleep sets both flags.
// - After power-on every interrupt source stays disabled until software enables it.
// - Reset clears watchdog and time-base counters; watchdog restarts from zero.
// - After power-on all timer modules are off until software enables them.
// - After power-on all port direction bits are one, pins are inputs.
// - After power-on the stack pointer points at the stack top.
// - Idle watchdog reset keeps registers; other resets load defaults.
// - Idle watchdog reset still clears program counter and stack pointer.
`timescale 1ns/1ps

module rsi_reset_state
    import rsi_pkg::*;
#(
    parameter int PC_W    = 13,
    parameter int SP_W    = 3,
    parameter int WDT_W   = 16,
    parameter int TB_W    = 16,
    parameter int TMR_W   = 4
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_in,
    input  wire rsi_pkg::rsi_event_s   event_in,
    input  wire rsi_pkg::rsi_mode_e    mode_in,
    input  wire logic                  clr_flags_in,
    input  wire logic                  sleep_entry_in,
    input  wire logic                  wdt_clear_in,
    input  wire logic                  fetch_step_in,
    input  wire rsi_pkg::rsi_sw_wr_s   sw_wr_in,
    output rsi_pkg::rsi_flags_s        flags_out,
    output rsi_pkg::rsi_kind_e         last_kind_out,
    output logic                       core_hold_out,
    output logic [PC_W-1:0]            pc_out,
    output logic [SP_W-1:0]            sp_out,
    output logic [WDT_W-1:0]           wdt_count_out,
    output logic [TB_W-1:0]            tb_count_out,
    output logic [7:0]                 int_en_out,
    output logic [TMR_W-1:0]           tmr_en_out,
    output logic [7:0]                 dir_a_out,
    output logic [7:0]                 dir_b_out
);
    import rsi_pkg::*;

    localparam logic [SP_W-1:0] SP_TOP   = '0;
    localparam logic [PC_W-1:0] PC_RESET = '0;

    rsi_kind_e  kind_next;
    logic       any_event;
    logic       idle_mode;
    logic       load_default;
    logic       sw_ok;
    logic [7:0] int_en_q;
    logic [TMR_W-1:0] tmr_en_q;
    logic [7:0] dir_a_q;
    logic [7:0] dir_b_q;

    // Classify the incoming reset; power-on wins, then watchdog, then low voltage.
    always_comb begin
        idle_mode = (mode_in == RSI_MODE_IDLE) || (mode_in == RSI_MODE_SLEEP);
        if (rst_in) begin
            kind_next = RSI_KIND_POR;
        end else if (event_in.watchdog_timer) begin
            kind_next = idle_mode ? RSI_KIND_WDT_IDLE : RSI_KIND_WDT_RUN;
        end else if (event_in.low_voltage_reset && !idle_mode) begin
            kind_next = RSI_KIND_LVR;   // Low-voltage detection is off in idle or sleep.
        end else begin
            kind_next = RSI_KIND_NONE;
        end
        any_event = (kind_next != RSI_KIND_NONE);
    end

    // retention choice
    // Only the idle watchdog reset keeps register contents.
    assign load_default = any_event && (kind_next != RSI_KIND_WDT_IDLE);
    // Software writes are ignored while the core is held or a reset arrives.
    assign sw_ok = sw_wr_in.we && !any_event && !core_hold_out;

    // Remember which reset came last so software can tell the cause.
    always_ff @(posedge sys_clk_in) begin
        if (any_event) begin
            last_kind_out <= kind_next;
        end
    end

    // hold then release
    // The core is held during power-on reset and one cycle after any event.
    always_ff @(posedge sys_clk_in) begin
        core_hold_out <= any_event;
    end

    // flags on reset
    // Reset events outrank software so a set is never lost to a clear.
    always_ff @(posedge sys_clk_in) begin
        case (kind_next)
            RSI_KIND_POR: begin
                flags_out.timeout_flag   <= RSI_FLAG_POR;
                flags_out.powerdown_flag <= RSI_FLAG_POR;
            end
            RSI_KIND_WDT_RUN: begin
                flags_out.timeout_flag   <= RSI_FLAG_SET;
            end
            RSI_KIND_WDT_IDLE: begin
                flags_out.timeout_flag   <= RSI_FLAG_SET;
                flags_out.powerdown_flag <= RSI_FLAG_SET;
            end
            RSI_KIND_LVR: begin
                flags_out <= flags_out;
            end
            RSI_KIND_NONE: begin
                if (clr_flags_in) begin
                    flags_out <= '0;
                end else if (sleep_entry_in) begin
                    flags_out.timeout_flag   <= 1'b0;
                    flags_out.powerdown_flag <= 1'b1;
                end
            end
            default: begin
                flags_out <= flags_out;
            end
        endcase
    end

    // core pointers cleared
    // Every reset kind, the idle watchdog one included, restarts the core at zero.
    always_ff @(posedge sys_clk_in) begin
        if (any_event) begin
            pc_out <= PC_RESET;
        end else if (fetch_step_in && !core_hold_out) begin
            pc_out <= pc_out + PC_W'(1);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (any_event) begin
            sp_out <= SP_TOP;
        end
    end

    // counters restart
    // The watchdog counts on from zero in the very cycle after reset.
    always_ff @(posedge sys_clk_in) begin
        if (any_event || wdt_clear_in) begin
            wdt_count_out <= '0;
        end else begin
            wdt_count_out <= wdt_count_out + WDT_W'(1);
        end
    end

    // Time base runs freely between resets.
    always_ff @(posedge sys_clk_in) begin
        if (any_event) begin
            tb_count_out <= '0;
        end else begin
            tb_count_out <= tb_count_out + TB_W'(1);
        end
    end

    rsi_def_reg #(.WIDTH(8), .DEFAULT(RSI_INT_EN_RST)) u_int_en (
        .sys_clk_in      (sys_clk_in),
        .load_default_in (load_default),
        .we_in           (sw_ok && (sw_wr_in.sel == RSI_SEL_INT_EN)),
        .wdata_in        (sw_wr_in.data),
        .q_out           (int_en_q)
    );

    // timers off
    // Only the low bits of the write carry timer enables; the rest are dropped on purpose.
    rsi_def_reg #(.WIDTH(TMR_W), .DEFAULT(RSI_TMR_EN_RST[TMR_W-1:0])) u_tmr_en (
        .sys_clk_in      (sys_clk_in),
        .load_default_in (load_default),
        .we_in           (sw_ok && (sw_wr_in.sel == RSI_SEL_TMR_EN)),
        .wdata_in        (sw_wr_in.data[TMR_W-1:0]),
        .q_out           (tmr_en_q)
    );

    rsi_def_reg #(.WIDTH(8), .DEFAULT(RSI_DIR_RST)) u_dir_a (
        .sys_clk_in      (sys_clk_in),
        .load_default_in (load_default),
        .we_in           (sw_ok && (sw_wr_in.sel == RSI_SEL_DIR_A)),
        .wdata_in        (sw_wr_in.data),
        .q_out           (dir_a_q)
    );

    rsi_def_reg #(.WIDTH(8), .DEFAULT(RSI_DIR_RST)) u_dir_b (
        .sys_clk_in      (sys_clk_in),
        .load_default_in (load_default),
        .we_in           (sw_ok && (sw_wr_in.sel == RSI_SEL_DIR_B)),
        .wdata_in        (sw_wr_in.data),
        .q_out           (dir_b_q)
    );

    // Outputs are the register flops themselves.
    assign int_en_out = int_en_q;
    assign tmr_en_out = tmr_en_q;
    assign dir_a_out  = dir_a_q;
    assign dir_b_out  = dir_b_q;

    // Checks on the reset behaviour follow.

    a_por_flags_clear: assert property (@(posedge sys_clk_in)
        $fell(rst_in) |-> (flags_out == '0))
        else $error("flags not cleared by power-on reset");

    a_lvr_flags_kept: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (event_in.low_voltage_reset && !event_in.watchdog_timer && !idle_mode)
        |=> (flags_out == $past(flags_out)))
        else $error("low-voltage reset changed flags");

    a_wdt_run_flags: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (event_in.watchdog_timer && !idle_mode)
        |=> flags_out.timeout_flag && (flags_out.powerdown_flag == $past(flags_out.powerdown_flag)))
        else $error("running watchdog reset flags wrong");

    a_wdt_idle_flags: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (event_in.watchdog_timer && idle_mode) |=> (flags_out == 2'b11))
        else $error("idle watchdog reset flags wrong");

    a_int_off_por: assert property (@(posedge sys_clk_in)
        $fell(rst_in) |-> (int_en_out == RSI_INT_EN_RST))
        else $error("interrupts enabled after power-on");

    a_wdt_count_restart: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (any_event && !wdt_clear_in) |=> (wdt_count_out == '0) && (tb_count_out == '0)
        ##1 ((wdt_count_out == WDT_W'(1)) || $past(wdt_clear_in) || $past(any_event)))
        else $error("watchdog did not restart from zero");

    a_tmr_off_por: assert property (@(posedge sys_clk_in)
        $fell(rst_in) |-> (tmr_en_out == '0))
        else $error("timers running after power-on");

    a_dir_input_por: assert property (@(posedge sys_clk_in)
        $fell(rst_in) |-> (dir_a_out == RSI_DIR_RST) && (dir_b_out == RSI_DIR_RST))
        else $error("ports not inputs after power-on");

    a_sp_top_por: assert property (@(posedge sys_clk_in)
        $fell(rst_in) |-> (sp_out == SP_TOP))
        else $error("stack pointer not at top");

    a_idle_keep_regs: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (event_in.watchdog_timer && idle_mode)
        |=> $stable(int_en_out) && $stable(dir_a_out) && $stable(tmr_en_out)
            && $stable(dir_b_out))
        else $error("idle watchdog reset altered registers");

    a_idle_pc_sp: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (event_in.watchdog_timer && idle_mode) |=> (pc_out == '0) && (sp_out == '0))
        else $error("pc or sp not cleared on idle watchdog");

    a_release_timing: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (event_in.watchdog_timer && !idle_mode)
        |=> core_hold_out && (int_en_out == RSI_INT_EN_RST) && (pc_out == '0)
        ##1 (!core_hold_out || $past(any_event)))
        else $error("defaults not in place at core release");

endmodule

// ==== sim/rsi_reset_state_tb_top.sv ====
// Self-checking testbench for the reset initial state logic.
`timescale 1ns/1ps

module rsi_reset_state_tb_top;
    import rsi_pkg::*;

    logic            sys_clk_in;
    logic            rst_in;
    rsi_event_s      event_in;
    rsi_mode_e       mode_in;
    logic            clr_flags_in;
    logic            sleep_entry_in;
    logic            wdt_clear_in;
    logic            fetch_step_in;
    rsi_sw_wr_s      sw_wr_in;
    rsi_flags_s      flags_out;
    rsi_kind_e       last_kind_out;
    logic            core_hold_out;
    logic [12:0]     pc_out;
    logic [2:0]      sp_out;
    logic [15:0]     wdt_count_out;
    logic [15:0]     tb_count_out;
    logic [7:0]      int_en_out;
    logic [3:0]      tmr_en_out;
    logic [7:0]      dir_a_out;
    logic [7:0]      dir_b_out;
    int              miscompares = 0;
    int              cmp_count = 0;
    int              cycles = 0;
    logic [15:0]     lfsr = 16'hf241;
    logic [7:0]      e_int;
    logic [3:0]      e_tmr;
    logic [7:0]      e_dira;
    logic [7:0]      e_dirb;
    rsi_flags_s      e_flags;

    rsi_reset_state rsi_reset_state_i (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .event_in(event_in),
        .mode_in(mode_in), .clr_flags_in(clr_flags_in), .sleep_entry_in(sleep_entry_in),
        .wdt_clear_in(wdt_clear_in), .fetch_step_in(fetch_step_in), .sw_wr_in(sw_wr_in),
        .flags_out(flags_out), .last_kind_out(last_kind_out), .core_hold_out(core_hold_out),
        .pc_out(pc_out), .sp_out(sp_out), .wdt_count_out(wdt_count_out),
        .tb_count_out(tb_count_out), .int_en_out(int_en_out), .tmr_en_out(tmr_en_out),
        .dir_a_out(dir_a_out), .dir_b_out(dir_b_out)
    );

    // The 25 MHz system clock.
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // Hang guard: the whole sequence needs well under a thousand cycles.
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            close_out();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Reset kind that a watchdog or low-voltage event should produce in a given mode.
    function automatic rsi_kind_e kind_of(input logic [1:0] ev, input rsi_mode_e m);
        if (ev[0]) begin
            return (m inside {RSI_MODE_IDLE, RSI_MODE_SLEEP}) ? RSI_KIND_WDT_IDLE
                                                              : RSI_KIND_WDT_RUN;
        end
        return RSI_KIND_LVR;
    endfunction

    // Expected status flags after a reset of the given kind.
    function automatic rsi_flags_s flags_after(input rsi_kind_e k, input rsi_flags_s f);
        case (k)
            RSI_KIND_POR: return '{timeout_flag: 1'b0, powerdown_flag: 1'b0};
            RSI_KIND_WDT_RUN: return '{timeout_flag: 1'b1, powerdown_flag: f.powerdown_flag};
            RSI_KIND_WDT_IDLE: return '{timeout_flag: 1'b1, powerdown_flag: 1'b1};
            default: return f;
        endcase
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic load_defaults();
        e_int = RSI_INT_EN_RST;
        e_tmr = RSI_TMR_EN_RST[3:0];
        e_dira = RSI_DIR_RST;
        e_dirb = RSI_DIR_RST;
    endtask

    // Compares every reset-defaulted register with the bench's own copy.
    task automatic check_regs();
        check("int_en", {8'h00, int_en_out}, {8'h00, e_int});
        check("tmr_en", {12'h000, tmr_en_out}, {12'h000, e_tmr});
        check("dir_a", {8'h00, dir_a_out}, {8'h00, e_dira});
        check("dir_b", {8'h00, dir_b_out}, {8'h00, e_dirb});
    endtask

    // Checks the state one cycle after a reset has been taken, then the restart cycle.
    task automatic check_after(input rsi_kind_e k);
        check("flags", {14'h0, flags_out}, {14'h0, e_flags});
        check("kind", {13'h0, last_kind_out}, {13'h0, k});
        check("hold", {15'h0, core_hold_out}, 16'h0001);
        check("pc", {3'h0, pc_out}, 16'h0000);
        check("sp", {13'h0, sp_out}, 16'h0000);
        check("wdt", wdt_count_out, 16'h0000);
        check("tbase", tb_count_out, 16'h0000);
        check_regs();
        @(posedge sys_clk_in);
        #1;
        check("hold_rel", {15'h0, core_hold_out}, 16'h0000);
        check("wdt_run", wdt_count_out, 16'h0001);
    endtask

    task automatic do_por(input string name);
        @(posedge sys_clk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        #1;
        e_flags = flags_after(RSI_KIND_POR, e_flags);
        load_defaults();
        check_after(RSI_KIND_POR);
        $display("test %s done", name);
    endtask

    // A write is taken at the second edge; the select picks the target register.
    task automatic sw_write(input logic [1:0] s, input logic [7:0] d);
        @(posedge sys_clk_in);
        sw_wr_in <= '{we: 1'b1, sel: rsi_sel_e'(s), data: d};
        @(posedge sys_clk_in);
        sw_wr_in.we <= 1'b0;
        if (s == 2'd0) e_int = d;
        else if (s == 2'd1) e_tmr = d[3:0];
        else if (s == 2'd2) e_dira = d;
        else e_dirb = d;
    endtask

    // Drives two-cycle pulses on the flag, fetch and watchdog-clear inputs.
    task automatic side_ops(input logic [15:0] r);
        @(posedge sys_clk_in);
        sleep_entry_in <= r[0];
        clr_flags_in <= ~r[0] & r[1];
        wdt_clear_in <= r[2];
        fetch_step_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        {sleep_entry_in, clr_flags_in, wdt_clear_in, fetch_step_in} <= 4'h0;
        #1;
        check("pc_step", {3'h0, pc_out}, 16'h0002);
        if (r[2]) check("wdt_clr", wdt_count_out, 16'h0000);
        if (r[0]) e_flags = '{timeout_flag: 1'b0, powerdown_flag: 1'b1};
        else if (r[1]) e_flags = '{timeout_flag: 1'b0, powerdown_flag: 1'b0};
    endtask

    // A reset event pulse together with a write that must be refused.
    task automatic fire(input logic [1:0] ev, input rsi_mode_e m, input logic [7:0] d);
        rsi_kind_e k;
        @(posedge sys_clk_in);
        event_in <= rsi_event_s'(ev);
        mode_in <= m;
        sw_wr_in <= '{we: 1'b1, sel: RSI_SEL_DIR_A, data: d};
        @(posedge sys_clk_in);
        event_in <= '0;
        sw_wr_in.we <= 1'b0;
        #1;
        k = kind_of(ev, m);
        e_flags = flags_after(k, e_flags);
        if (k != RSI_KIND_WDT_IDLE) load_defaults();
        check_after(k);
    endtask

    // Low-voltage detection is off in sleep, so the pulse is no reset and the write lands.
    task automatic lvr_idle(input logic [7:0] d);
        @(posedge sys_clk_in);
        event_in <= '{low_voltage_reset: 1'b1, watchdog_timer: 1'b0};
        mode_in <= RSI_MODE_SLEEP;
        sw_wr_in <= '{we: 1'b1, sel: RSI_SEL_DIR_A, data: d};
        @(posedge sys_clk_in);
        event_in <= '0;
        sw_wr_in.we <= 1'b0;
        e_dira = d;
        #1;
        check("hold_lvr", {15'h0, core_hold_out}, 16'h0000);
        check("flags_lvr", {14'h0, flags_out}, {14'h0, e_flags});
        check_regs();
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Main sequence: power-on, random writes, watchdog events in every mode, low-voltage events in fast and slow then sleep, power-on again.
    initial begin
        rst_in = 1'b1;
        event_in = '0;
        mode_in = RSI_MODE_FAST;
        {clr_flags_in, sleep_entry_in, wdt_clear_in, fetch_step_in} = 4'h0;
        sw_wr_in = '0;
        e_flags = '{timeout_flag: 1'b1, powerdown_flag: 1'b1};
        do_por("power_on");
        for (int i = 0; i < 16; i++) begin
            rsi_mode_e m;
            m = rsi_mode_e'(i[1:0]);
            for (int j = 0; j < 3; j++) begin
                lfsr = lfsr_next(lfsr);
                sw_write(lfsr[9:8], lfsr[7:0]);
            end
            lfsr = lfsr_next(lfsr);
            side_ops(lfsr);
            fire((i[1] || i[2]) ? 2'b01 : 2'b10, m, ~lfsr[15:8]);
            $display("test event_%0d done", i);
        end
        lfsr = lfsr_next(lfsr);
        lvr_idle(lfsr[7:0]);
        $display("test lvr_idle done");
        do_por("mid_run");
        close_out();
    end
endmodule
